/* File: src/mos_pkg.sv */
package mos_pkg;

  // Register byte offsets.
  localparam logic [5:0] MOS_OFS_FUNC = 6'h00;
  localparam logic [5:0] MOS_OFS_ALARM = 6'h04;
  localparam logic [5:0] MOS_OFS_BRAKE = 6'h08;
  localparam logic [5:0] MOS_OFS_STATUS = 6'h0c;
  localparam logic [5:0] MOS_OFS_QUERY = 6'h10;
  localparam logic [5:0] MOS_OFS_QUERY_PT = 6'h14;

  // Field positions inside the function register.
  localparam int MOS_FUNC_CODE_LSB = 0;
  localparam int MOS_FUNC_PT_LSB = 4;
  // Field positions inside the status register.
  localparam int MOS_ST_MOVING_BIT = 0;
  localparam int MOS_ST_LEVEL_LSB = 4;
  localparam int MOS_ST_DIR_LSB = 8;

  // Function codes.
  localparam logic [3:0] MOS_CODE_LOW_MOVING = 4'h1;
  localparam logic [3:0] MOS_CODE_HIGH_MOVING = 4'h2;
  localparam logic [3:0] MOS_CODE_RELEASED = 4'h3;
  localparam logic [3:0] MOS_CODE_TACH_FIRST = 4'h4;
  localparam logic [3:0] MOS_CODE_TACH_LAST = 4'h8;

  // Number of I/O points and valid point range.
  localparam int MOS_NUM_POINTS = 4;
  localparam logic [2:0] MOS_PT_NONE = 3'h0;
  localparam logic [2:0] MOS_PT_FIRST = 3'h1;
  localparam logic [2:0] MOS_PT_LAST = 3'h4;

  // Values after reset.
  localparam logic [3:0] MOS_RST_CODE = MOS_CODE_RELEASED;
  localparam logic [2:0] MOS_RST_PT = MOS_PT_FIRST;
  localparam logic [2:0] MOS_RST_ALARM_PT = MOS_PT_NONE;
  localparam logic [2:0] MOS_RST_BRAKE_PT = MOS_PT_NONE;

  // Step input resolution and tach divider at the coarsest rate.
  // 3200 steps per revolution; 100 pulses per revolution need a
  // toggle every 16 steps, each faster rate halves that.
  localparam int MOS_STEPS_PER_REV = 3200;
  localparam int MOS_TACH_MIN_PPR = 100;
  localparam logic [4:0] MOS_TACH_DIV_MAX =
    5'(MOS_STEPS_PER_REV / (2 * MOS_TACH_MIN_PPR));

  // Query characters.
  localparam logic [7:0] MOS_CHR_M = 8'h4d;
  localparam logic [7:0] MOS_CHR_O = 8'h4f;
  localparam logic [7:0] MOS_CHR_EQ = 8'h3d;
  localparam logic [7:0] MOS_CHR_ZERO = 8'h30;

endpackage

/* File: src/mos_tach.sv */
`timescale 1ns/100ps
module mos_tach (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic step,
  input wire logic clear,
  input wire logic [4:0] div,
  output logic level
);
  import mos_pkg::*;

  typedef struct packed {
    logic [4:0] cnt;
    logic level;
  } mos_tach_s;

  mos_tach_s st_q;
  mos_tach_s st_d;

  always_comb begin
    st_d = st_q;
    if (clear) begin
      st_d.cnt = 5'h00;
      st_d.level = 1'b0;
    end else if (step) begin
      if (st_q.cnt >= div - 5'h01) begin
        st_d.cnt = 5'h00;
        st_d.level = ~st_q.level;
      end else begin
        st_d.cnt = st_q.cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level = st_q.level;
endmodule // mos_tach

/* File: src/mos_top.sv */
// Functional notes
// - Code 1 drives the chosen output low (closed) while the motor moves.
// - Code 2 holds the chosen output high (open) while the motor moves.
// - Code 3 releases the output for other automatic or general use.
// - Codes 4 to 8 emit tach at 100, 200, 400, 800, 1600 per rev.
// - Writing codes 1, 2 or 4 to 8 overrides previous output assignment.
// - Alarm or brake assigned to the same output forces code 3.
// - The first numeral selects I/O point 1 to 4 for the function.
// - Two numerals: the output used, then the function code.
// - Energized means logic low (closed); de-energized means high (open).
// - Only one function owns an output at any time.
`timescale 1ns/100ps
module mos_top (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic motor_moving,
  input wire logic motor_step,
  input wire logic [mos_pkg::MOS_NUM_POINTS-1:0] io_dir_out,
  input wire logic alarm_level,
  input wire logic brake_level,
  input wire logic [mos_pkg::MOS_NUM_POINTS-1:0] gp_level,
  output logic [mos_pkg::MOS_NUM_POINTS-1:0] io_level,
  output logic [mos_pkg::MOS_NUM_POINTS-1:0] io_energize
);
  import mos_pkg::*;

  typedef struct packed {
    logic [3:0] code;
    logic [2:0] point;
    logic [2:0] alarm_pt;
    logic [2:0] brake_pt;
    logic ack;
    logic [31:0] rdata;
    logic [MOS_NUM_POINTS-1:0] level;
  } mos_state_s;

  mos_state_s st_q;
  mos_state_s st_d;

  logic req;
  logic wr_take;
  logic tach_level;
  logic tach_clear;
  logic [4:0] tach_div;
  logic motion_owns;
  logic [3:0] wr_code;
  logic [2:0] wr_point;
  logic [2:0] wr_sel_pt;

  function automatic logic code_claims(input logic [3:0] c);
    code_claims = (c == MOS_CODE_LOW_MOVING) ||
                  (c == MOS_CODE_HIGH_MOVING) ||
                  (c >= MOS_CODE_TACH_FIRST && c <= MOS_CODE_TACH_LAST);
  endfunction

  function automatic logic pt_valid(input logic [2:0] p);
    pt_valid = (p >= MOS_PT_FIRST) && (p <= MOS_PT_LAST);
  endfunction

  // One wait state: the read word is latched on the first edge so that
  // it already stands at the edge where waitrequest is sampled low.
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~st_q.ack;
  assign wr_take = avs_write & st_q.ack;

  assign wr_code = avs_writedata[MOS_FUNC_CODE_LSB +: 4];
  assign wr_point = avs_writedata[MOS_FUNC_PT_LSB +: 3];
  assign wr_sel_pt = avs_writedata[2:0];

  assign motion_owns = code_claims(st_q.code);

  // Each faster tach rate halves the step divider.
  assign tach_div = (st_q.code >= MOS_CODE_TACH_FIRST &&
                     st_q.code <= MOS_CODE_TACH_LAST) ?
                    (MOS_TACH_DIV_MAX >> (st_q.code - MOS_CODE_TACH_FIRST)) :
                    MOS_TACH_DIV_MAX;
  assign tach_clear = (st_q.code < MOS_CODE_TACH_FIRST) ||
                      (st_q.code > MOS_CODE_TACH_LAST);

  mos_tach u_tach (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .step(motor_step),
    .clear(tach_clear),
    .div(tach_div),
    .level(tach_level)
  );

  // Ownership is settled by a fixed priority every cycle, so a point is
  // fed by exactly one source even while two selects briefly overlap.
  always_comb begin
    st_d = st_q;
    st_d.ack = req & ~st_q.ack;

    if (wr_take) begin
      case (avs_address)
        MOS_OFS_FUNC: begin
          // Codes outside 1 to 8 and points outside 1 to 4 are ignored.
          if (wr_code >= MOS_CODE_LOW_MOVING &&
              wr_code <= MOS_CODE_TACH_LAST &&
              pt_valid(wr_point)) begin
            st_d.code = wr_code;
            st_d.point = wr_point;
            if (code_claims(wr_code)) begin
              if (st_q.alarm_pt == wr_point) begin
                st_d.alarm_pt = MOS_PT_NONE;
              end
              if (st_q.brake_pt == wr_point) begin
                st_d.brake_pt = MOS_PT_NONE;
              end
            end
          end
        end
        MOS_OFS_ALARM: begin
          if (pt_valid(wr_sel_pt) || wr_sel_pt == MOS_PT_NONE) begin
            st_d.alarm_pt = wr_sel_pt;
            if (wr_sel_pt == st_q.point && motion_owns) begin
              st_d.code = MOS_CODE_RELEASED;
            end
            if (wr_sel_pt == st_q.brake_pt) begin
              st_d.brake_pt = MOS_PT_NONE;
            end
          end
        end
        MOS_OFS_BRAKE: begin
          if (pt_valid(wr_sel_pt) || wr_sel_pt == MOS_PT_NONE) begin
            st_d.brake_pt = wr_sel_pt;
            if (wr_sel_pt == st_q.point && motion_owns) begin
              st_d.code = MOS_CODE_RELEASED;
            end
            if (wr_sel_pt == st_q.alarm_pt) begin
              st_d.alarm_pt = MOS_PT_NONE;
            end
          end
        end
        default: begin
        end
      endcase
    end

    if (avs_read & ~st_q.ack) begin
      case (avs_address)
        MOS_OFS_FUNC: begin
          st_d.rdata = 32'h0000_0000;
          st_d.rdata[MOS_FUNC_CODE_LSB +: 4] = st_q.code;
          st_d.rdata[MOS_FUNC_PT_LSB +: 3] = st_q.point;
        end
        MOS_OFS_ALARM: begin
          st_d.rdata = {29'h0000_0000, st_q.alarm_pt};
        end
        MOS_OFS_BRAKE: begin
          st_d.rdata = {29'h0000_0000, st_q.brake_pt};
        end
        MOS_OFS_STATUS: begin
          st_d.rdata = 32'h0000_0000;
          st_d.rdata[MOS_ST_MOVING_BIT] = motor_moving;
          st_d.rdata[MOS_ST_LEVEL_LSB +: MOS_NUM_POINTS] = st_q.level;
          st_d.rdata[MOS_ST_DIR_LSB +: MOS_NUM_POINTS] = io_dir_out;
        end
        MOS_OFS_QUERY: begin
          st_d.rdata = {MOS_CHR_M, MOS_CHR_O, MOS_CHR_EQ,
                        MOS_CHR_ZERO + {4'h0, st_q.code}};
        end
        MOS_OFS_QUERY_PT: begin
          st_d.rdata = {24'h00_0000,
                        MOS_CHR_ZERO + {5'h00, st_q.point}};
        end
        default: begin
          st_d.rdata = 32'h0000_0000;
        end
      endcase
    end

    // Level 1 is open (high), level 0 is closed (low).
    for (int i = 0; i < MOS_NUM_POINTS; i++) begin
      if (motion_owns && st_q.point == 3'(i + 1)) begin
        // A point still set as an input is left open; the host is
        // expected to set the direction first.
        if (!io_dir_out[i]) begin
          st_d.level[i] = 1'b1;
        end else if (st_q.code == MOS_CODE_LOW_MOVING) begin
          st_d.level[i] = ~motor_moving;
        end else if (st_q.code == MOS_CODE_HIGH_MOVING) begin
          st_d.level[i] = motor_moving;
        end else begin
          st_d.level[i] = ~tach_level;
        end
      end else if (st_q.alarm_pt == 3'(i + 1)) begin
        st_d.level[i] = alarm_level;
      end else if (st_q.brake_pt == 3'(i + 1)) begin
        st_d.level[i] = brake_level;
      end else begin
        st_d.level[i] = gp_level[i];
      end
    end
  end

  // The points reset open, so nothing is energized until the cycle after reset,
  // when the points no function owns start to follow gp_level.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_q.code <= MOS_RST_CODE;
      st_q.point <= MOS_RST_PT;
      st_q.alarm_pt <= MOS_RST_ALARM_PT;
      st_q.brake_pt <= MOS_RST_BRAKE_PT;
      st_q.ack <= 1'b0;
      st_q.rdata <= 32'h0000_0000;
      st_q.level <= '1;
    end else begin
      st_q <= st_d;
    end
  end

  assign avs_readdata = st_q.rdata;
  assign io_level = st_q.level;
  assign io_energize = ~st_q.level;
endmodule // mos_top

/* File: testbench/mos_motor_model.sv */
`timescale 1ns/100ps
module mos_motor_model (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic run,
  output logic motor_moving,
  output logic motor_step
);
  logic [1:0] cnt_q;
  // A step every fourth cycle leaves gaps the tach divider must bridge.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 2'h0;
      motor_step <= 1'h0;
    end else begin
      cnt_q <= run ? cnt_q + 2'h1 : 2'h0;
      motor_step <= run && cnt_q == 2'h3;
    end
  end
  assign motor_moving = run;
endmodule // mos_motor_model

/* File: testbench/mos_top_asserts.sv */
`timescale 1ns/100ps
module mos_top_chk
  import mos_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic motor_moving,
  input wire logic motor_step,
  input wire logic [MOS_NUM_POINTS-1:0] io_dir_out,
  input wire logic alarm_level,
  input wire logic brake_level,
  input wire logic [MOS_NUM_POINTS-1:0] gp_level,
  input wire logic [MOS_NUM_POINTS-1:0] io_level,
  input wire logic [MOS_NUM_POINTS-1:0] io_energize
);
  typedef struct packed {
    logic [3:0] code;
    logic [2:0] pt;
  } mos_chk_s;
  mos_chk_s st_q, st_d;
  logic req, take, wr;
  logic [1:0] ix, aix;
  assign req = avs_read | avs_write;
  assign take = req & ~avs_waitrequest;
  assign wr = take & avs_write;
  assign ix = 2'(st_q.pt - 3'h1);
  assign aix = avs_writedata[1:0] - 2'h1;
  // Shadow of the function register, so output checks know the owner.
  always_comb begin
    st_d = st_q;
    if (wr && avs_address == MOS_OFS_FUNC &&
        avs_writedata[3:0] inside {[4'h1:4'h8]} &&
        avs_writedata[6:4] inside {[3'h1:3'h4]})
      st_d = {avs_writedata[3:0], avs_writedata[6:4]};
    if (wr && avs_address inside {MOS_OFS_ALARM, MOS_OFS_BRAKE} &&
        avs_writedata[2:0] == st_q.pt)
      st_d.code = MOS_CODE_RELEASED;
  end
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn) st_q <= {MOS_RST_CODE, MOS_RST_PT};
    else st_q <= st_d;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  chk_wait_first: assert property ($rose(req) |-> avs_waitrequest)
    else $error("no wait cycle on new request");
  chk_wait_once: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("request stalled beyond one cycle");
  chk_energize_inv: assert property (io_energize == ~io_level)
    else $error("energize is not the inverse of level");
  chk_query_name: assert property (take && avs_read &&
    avs_address == MOS_OFS_QUERY |-> avs_readdata == {MOS_CHR_M, MOS_CHR_O,
    MOS_CHR_EQ, 8'(MOS_CHR_ZERO + st_q.code)})
    else $error("query word wrong");
  chk_query_point: assert property (take && avs_read &&
    avs_address == MOS_OFS_QUERY_PT |->
    avs_readdata == {24'h0, 8'(MOS_CHR_ZERO + st_q.pt)})
    else $error("point query wrong");
  chk_low_moving: assert property (st_q.code == 4'h1 && io_dir_out[ix]
    |=> io_level[$past(ix)] == !$past(motor_moving))
    else $error("code 1 output wrong");
  chk_high_moving: assert property (st_q.code == 4'h2 && io_dir_out[ix]
    |=> io_level[$past(ix)] == $past(motor_moving))
    else $error("code 2 output wrong");
  chk_alarm_owns: assert property (wr && avs_address == MOS_OFS_ALARM &&
    avs_writedata[2:0] inside {[3'h1:3'h4]} |->
    ##2 io_level[$past(aix, 2)] == $past(alarm_level))
    else $error("alarm does not own its output");
  cover property (wr && avs_address == MOS_OFS_FUNC);
  cover property (st_q.code == MOS_CODE_TACH_LAST && motor_step);
  cover property (take && avs_read && avs_address == MOS_OFS_QUERY);
endmodule // mos_top_chk
bind mos_top mos_top_chk u_mos_top_chk (.clk_sys, .rstn, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
  .motor_moving, .motor_step, .io_dir_out, .alarm_level, .brake_level,
  .gp_level, .io_level, .io_energize);

/* File: testbench/tb_mos_top.sv */
`timescale 1ns/100ps
module tb_mos_top;
  import mos_pkg::*;
  logic clk_sys = 1'h0, rstn = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
  logic run = 1'h0, alarm_level = 1'h1, brake_level = 1'h0, lv_prev = 1'h1;
  logic [5:0] avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic avs_waitrequest, motor_moving, motor_step;
  logic [3:0] io_dir_out = 4'hf, gp_level = 4'ha, io_level, io_energize;
  int bad_count = 0, samples_checked = 0, cyc = 0, tog = 0, steps = 0;
  always #20 clk_sys = ~clk_sys;
  mos_top u_mos_top (.clk_sys, .rstn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .motor_moving,
    .motor_step, .io_dir_out, .alarm_level, .brake_level, .gp_level,
    .io_level, .io_energize);
  mos_motor_model u_mos_motor_model (.clk_sys, .rstn, .run, .motor_moving,
    .motor_step);
  task automatic end_of_test();
    if (bad_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Waitrequest is looked at mid-cycle so the take edge is never raced.
  task automatic xfer(input logic w, input logic [5:0] a,
                      input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(negedge clk_sys);
    while (avs_waitrequest !== 1'h0) @(negedge clk_sys);
    @(posedge clk_sys);
    if (!w) check("readdata", avs_readdata, d);
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask
  task automatic gap();
    repeat (3) @(negedge clk_sys);
  endtask
  always @(negedge clk_sys) begin
    if (io_level[0] !== lv_prev) tog++;
    lv_prev = io_level[0];
    if (motor_step === 1'h1) steps++;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rstn <= 1'h1;
    xfer(0, MOS_OFS_FUNC, 32'h13);
    xfer(0, MOS_OFS_QUERY, 32'h4d4f3d33);
    check("io_level", io_level, gp_level);
    xfer(1, MOS_OFS_FUNC, 32'h21);
    @(posedge clk_sys) run <= 1'h1;
    gap();
    check("io_level", io_level, 4'h8);
    check("io_energize", io_energize, 4'h7);
    @(posedge clk_sys) run <= 1'h0;
    gap();
    check("io_level", io_level, 4'ha);
    xfer(0, MOS_OFS_QUERY, 32'h4d4f3d31);
    xfer(0, MOS_OFS_QUERY_PT, 32'h32);
    xfer(1, MOS_OFS_FUNC, 32'h32);
    @(posedge clk_sys) run <= 1'h1;
    gap();
    check("io_level", io_level, 4'he);
    @(posedge clk_sys) run <= 1'h0;
    xfer(1, MOS_OFS_FUNC, 32'h39);
    xfer(1, MOS_OFS_FUNC, 32'h52);
    xfer(0, MOS_OFS_FUNC, 32'h32);
    xfer(1, MOS_OFS_ALARM, 32'h4);
    xfer(1, MOS_OFS_FUNC, 32'h41);
    xfer(0, MOS_OFS_ALARM, 32'h0);
    xfer(1, MOS_OFS_BRAKE, 32'h4);
    xfer(0, MOS_OFS_FUNC, 32'h43);
    gap();
    check("io_level", io_level, 4'h2);
    xfer(1, MOS_OFS_ALARM, 32'h4);
    xfer(0, MOS_OFS_BRAKE, 32'h0);
    @(posedge clk_sys) io_dir_out <= 4'he;
    xfer(1, MOS_OFS_FUNC, 32'h11);
    @(posedge clk_sys) run <= 1'h1;
    gap();
    check("io_level", io_level, 4'hb);
    xfer(0, MOS_OFS_STATUS, 32'h0eb1);
    @(posedge clk_sys) run <= 1'h0;
    io_dir_out <= 4'hf;
    for (int c = 4; c <= 8; c++) begin
      xfer(1, MOS_OFS_FUNC, 32'h13);
      xfer(1, MOS_OFS_FUNC, 32'h10 | 32'(c));
      gap();
      tog = 0;
      steps = 0;
      @(posedge clk_sys) run <= 1'h1;
      while (steps < 32) @(negedge clk_sys);
      @(posedge clk_sys) run <= 1'h0;
      gap();
      check("tach_toggles", 32'(tog), 32'(2 << (c - 4)));
    end
    xfer(0, 6'h3c, 32'h0);
    end_of_test();
  end
endmodule // tb_mos_top
